// *** afrb_pkg.sv ***
// constants of the alternate function remap bank: register map, field
// positions, reset value, write masks and pin and line geometry.
// assumes a 32-bit register port with byte addresses and one clock.
`default_nettype none

package afrb_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  EVT_CTRL_OFS    = 8'h00;
    localparam logic [7:0]  REMAP_OFS       = 8'h04;
    localparam logic [7:0]  LINE_SEL_0_OFS  = 8'h08;
    localparam logic [7:0]  LINE_SEL_1_OFS  = 8'h0c;
    localparam logic [7:0]  LINE_SEL_2_OFS  = 8'h10;
    localparam logic [7:0]  LINE_SEL_3_OFS  = 8'h14;

    localparam logic [31:0] REG_RESET       = 32'h0000_0000;
    localparam logic [31:0] EVT_CTRL_MASK   = 32'h0000_00ff;
    localparam logic [31:0] REMAP_MASK      = 32'he01f_ffff;
    localparam logic [31:0] LINE_SEL_MASK   = 32'h0000_ffff;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int EVT_EN_BIT        = 7;
    localparam int EVT_PORT_LSB      = 4;
    localparam int EVT_PIN_LSB       = 0;
    localparam logic [2:0] LAST_PORT = 3'h4;
    localparam logic [3:0] LAST_CODE = 4'h4;

    localparam int OPAMP_LSB         = 29;
    localparam int CONV2_REG_BIT     = 20;
    localparam int CONV2_INJ_BIT     = 19;
    localparam int CONV1_REG_BIT     = 18;
    localparam int CONV1_INJ_BIT     = 17;
    localparam int TIMER5_CH4_BIT    = 16;
    localparam int OSC_GPIO_BIT      = 15;
    localparam int CAN_LSB           = 13;
    localparam int TIMER4_BIT        = 12;
    localparam int TIMER3_LSB        = 10;
    localparam int TIMER2_LSB        = 8;
    localparam int TIMER1_LSB        = 6;
    localparam int SERIAL3_LSB       = 4;
    localparam int SERIAL2_BIT       = 3;
    localparam int SERIAL1_BIT       = 2;
    localparam int TWOWIRE1_BIT      = 1;
    localparam int SPI_ONE_BIT       = 0;

    // ------------------------------------------------------------------
    // pin and line geometry
    // ------------------------------------------------------------------
    localparam int PORTS             = 5;
    localparam int PINS              = 16;
    localparam int PIN_W             = PORTS * PINS;
    localparam int SYNC_W            = PIN_W + 1;
    localparam int PA3_IDX           = 3;
    localparam int LINE_TRIG_REG     = 11;
    localparam int LINE_TRIG_INJ     = 15;

endpackage : afrb_pkg

`default_nettype wire

// *** afrb_top.sv ***
// alternate function remap bank: register file, event pin steering,
// line source muxing, converter trigger selection and pin-set decodes.
// assumes a single-cycle register port on MCLK_I and that pin inputs
// and the slow oscillator arrive asynchronously.
`default_nettype none

module afrb_top
    import afrb_pkg::*;
(
    input  wire  logic              MCLK_I,
    input  wire  logic              RST_N_I,
    input  wire  logic              CE_I,
    input  wire  logic [7:0]        ADDR_I,
    input  wire  logic [31:0]       WDATA_I,
    input  wire  logic              WR_EN_I,
    input  wire  logic              RD_EN_I,
    output var   logic [31:0]       RDATA_O,
    input  wire  logic              CORE_EVENT_I,
    input  wire  logic [79:0]       PORT_IN_I,
    input  wire  logic              LOW_SPEED_OSC_I,
    input  wire  logic              TIMER8_TRIGGER_OUT_I,
    input  wire  logic              TIMER8_CH4_I,
    output var   logic [79:0]       EVENT_PIN_O,
    output var   logic [79:0]       EVENT_PIN_OE_O,
    output var   logic [15:0]       LINE_OUT_O,
    output var   logic              CONV1_REG_TRIG_O,
    output var   logic              CONV1_INJ_TRIG_O,
    output var   logic              CONV2_REG_TRIG_O,
    output var   logic              CONV2_INJ_TRIG_O,
    output var   logic              TIMER5_CH4_IN_O,
    output var   logic [2:0]        OPAMP_ROUTE_O,
    output var   logic              OSC_PINS_AS_GPIO_O,
    output var   logic [2:0]        CAN_PIN_SET_O,
    output var   logic              TIMER4_PIN_SET_O,
    output var   logic [2:0]        TIMER3_PIN_SET_O,
    output var   logic [3:0]        TIMER2_PIN_SET_O,
    output var   logic [2:0]        TIMER1_PIN_SET_O,
    output var   logic [2:0]        SERIAL3_PIN_SET_O,
    output var   logic              SERIAL2_PIN_SET_O,
    output var   logic              SERIAL1_PIN_SET_O,
    output var   logic              TWOWIRE1_PIN_SET_O,
    output var   logic              SPI_ONE_PIN_SET_O
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0]       evt_ctrl;
        logic [31:0]       remap;
        logic [63:0]       line_code;
        logic [31:0]       rdata;
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic [SYNC_W-1:0] sync3;
        logic [SYNC_W-1:0] filt;
        logic [79:0]       evt_pin;
        logic [79:0]       evt_oe;
        logic [15:0]       line_out;
        logic              conv1_reg;
        logic              conv1_inj;
        logic              conv2_reg;
        logic              conv2_inj;
        logic              t5ch4;
        logic [2:0]        opamp;
        logic              osc_gpio;
        logic [2:0]        can_set;
        logic              tim4;
        logic [2:0]        tim3;
        logic [3:0]        tim2;
        logic [2:0]        tim1;
        logic [2:0]        ser3;
        logic              ser2;
        logic              ser1;
        logic              twi1;
        logic              spi1;
    } afrb_state_t;

    afrb_state_t st;
    afrb_state_t next_st;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [6:0]  evt_idx;
        logic [3:0]  code;
        logic [1:0]  fld;
        logic [6:0]  src_idx;
        evt_idx = 7'h00;
        code    = 4'h0;
        fld     = 2'h0;
        src_idx = 7'h00;
        next_st = st;

        // register writes; reserved bits are masked so they stay zero
        if (WR_EN_I) begin
            case (ADDR_I)
                EVT_CTRL_OFS: begin
                    next_st.evt_ctrl = WDATA_I & EVT_CTRL_MASK;
                end
                REMAP_OFS: begin
                    next_st.remap = WDATA_I & REMAP_MASK;
                end
                LINE_SEL_0_OFS: begin
                    next_st.line_code[15:0] = WDATA_I[15:0];
                end
                LINE_SEL_1_OFS: begin
                    next_st.line_code[31:16] = WDATA_I[15:0];
                end
                LINE_SEL_2_OFS: begin
                    next_st.line_code[47:32] = WDATA_I[15:0];
                end
                LINE_SEL_3_OFS: begin
                    next_st.line_code[63:48] = WDATA_I[15:0];
                end
                default: begin
                    next_st.remap = next_st.remap;
                end
            endcase
        end

        // read data stands in the cycle after the strobe only
        next_st.rdata = REG_RESET;
        if (RD_EN_I) begin
            case (ADDR_I)
                EVT_CTRL_OFS: begin
                    next_st.rdata = st.evt_ctrl & EVT_CTRL_MASK;
                end
                REMAP_OFS: begin
                    next_st.rdata = st.remap & REMAP_MASK;
                end
                LINE_SEL_0_OFS: begin
                    next_st.rdata = {16'h0000, st.line_code[15:0]};
                end
                LINE_SEL_1_OFS: begin
                    next_st.rdata = {16'h0000, st.line_code[31:16]};
                end
                LINE_SEL_2_OFS: begin
                    next_st.rdata = {16'h0000, st.line_code[47:32]};
                end
                LINE_SEL_3_OFS: begin
                    next_st.rdata = {16'h0000, st.line_code[63:48]};
                end
                default: begin
                    next_st.rdata = REG_RESET;
                end
            endcase
        end

        // ------------------------------------------------------------------
        // pin input synchronisers
        // ------------------------------------------------------------------
        // three stages; a level is taken only when stages two and three
        // agree, which drops single-cycle metastable glitches
        next_st.sync1 = {LOW_SPEED_OSC_I, PORT_IN_I};
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        for (int i = 0; i < SYNC_W; i++) begin
            if (st.sync2[i] == st.sync3[i]) begin
                next_st.filt[i] = st.sync3[i];
            end
        end

        // ------------------------------------------------------------------
        // core event steering
        // ------------------------------------------------------------------
        // decoded from the next register value so a write reaches the pin
        // on the same edge as the register, same as every other field
        next_st.evt_pin = '0;
        next_st.evt_oe  = '0;
        evt_idx = {next_st.evt_ctrl[EVT_PORT_LSB +: 3],
                   next_st.evt_ctrl[EVT_PIN_LSB +: 4]};
        if (next_st.evt_ctrl[EVT_EN_BIT] &&
            next_st.evt_ctrl[EVT_PORT_LSB +: 3] <= LAST_PORT) begin
            next_st.evt_oe[evt_idx]  = 1'b1;
            next_st.evt_pin[evt_idx] = CORE_EVENT_I;
        end

        // ------------------------------------------------------------------
        // line source select
        // ------------------------------------------------------------------
        for (int x = 0; x < PINS; x++) begin
            code    = next_st.line_code[4*x +: 4];
            src_idx = {code[2:0], 4'(x)};
            if (code <= LAST_CODE) begin
                next_st.line_out[x] = st.filt[src_idx];
            end else begin
                next_st.line_out[x] = 1'b0;
            end
        end

        // ------------------------------------------------------------------
        // converter trigger and timer5 input selection
        // ------------------------------------------------------------------
        next_st.conv2_reg = next_st.remap[CONV2_REG_BIT] ?
            TIMER8_TRIGGER_OUT_I : st.line_out[LINE_TRIG_REG];
        next_st.conv2_inj = next_st.remap[CONV2_INJ_BIT] ?
            TIMER8_CH4_I : st.line_out[LINE_TRIG_INJ];
        next_st.conv1_reg = next_st.remap[CONV1_REG_BIT] ?
            TIMER8_TRIGGER_OUT_I : st.line_out[LINE_TRIG_REG];
        next_st.conv1_inj = next_st.remap[CONV1_INJ_BIT] ?
            TIMER8_CH4_I : st.line_out[LINE_TRIG_INJ];
        // slow oscillator passes the same synchroniser as the pins
        next_st.t5ch4 = next_st.remap[TIMER5_CH4_BIT] ?
            st.filt[PIN_W] : st.filt[PA3_IDX];

        // ------------------------------------------------------------------
        // pin-set decodes
        // ------------------------------------------------------------------
        next_st.opamp    = next_st.remap[OPAMP_LSB +: 3];
        next_st.osc_gpio = next_st.remap[OSC_GPIO_BIT];

        // unused codes leave every set deselected
        fld = next_st.remap[CAN_LSB +: 2];
        case (fld)
            2'h0:    next_st.can_set = 3'h1;
            2'h2:    next_st.can_set = 3'h2;
            2'h3:    next_st.can_set = 3'h4;
            default: next_st.can_set = 3'h0;
        endcase

        next_st.tim4 = next_st.remap[TIMER4_BIT];

        fld = next_st.remap[TIMER3_LSB +: 2];
        case (fld)
            2'h0:    next_st.tim3 = 3'h1;
            2'h2:    next_st.tim3 = 3'h2;
            2'h3:    next_st.tim3 = 3'h4;
            default: next_st.tim3 = 3'h0;
        endcase

        fld = next_st.remap[TIMER2_LSB +: 2];
        case (fld)
            2'h0:    next_st.tim2 = 4'h1;
            2'h1:    next_st.tim2 = 4'h2;
            2'h2:    next_st.tim2 = 4'h4;
            default: next_st.tim2 = 4'h8;
        endcase

        fld = next_st.remap[TIMER1_LSB +: 2];
        case (fld)
            2'h0:    next_st.tim1 = 3'h1;
            2'h1:    next_st.tim1 = 3'h2;
            2'h3:    next_st.tim1 = 3'h4;
            default: next_st.tim1 = 3'h0;
        endcase

        fld = next_st.remap[SERIAL3_LSB +: 2];
        case (fld)
            2'h0:    next_st.ser3 = 3'h1;
            2'h1:    next_st.ser3 = 3'h2;
            2'h3:    next_st.ser3 = 3'h4;
            default: next_st.ser3 = 3'h0;
        endcase

        next_st.ser2 = next_st.remap[SERIAL2_BIT];
        next_st.ser1 = next_st.remap[SERIAL1_BIT];
        next_st.twi1 = next_st.remap[TWOWIRE1_BIT];
        next_st.spi1 = next_st.remap[SPI_ONE_BIT];
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // clock enable low freezes everything, synchronisers included
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st <= '0;
        end else if (CE_I) begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign RDATA_O            = st.rdata;
    assign EVENT_PIN_O        = st.evt_pin;
    assign EVENT_PIN_OE_O     = st.evt_oe;
    assign LINE_OUT_O         = st.line_out;
    assign CONV1_REG_TRIG_O   = st.conv1_reg;
    assign CONV1_INJ_TRIG_O   = st.conv1_inj;
    assign CONV2_REG_TRIG_O   = st.conv2_reg;
    assign CONV2_INJ_TRIG_O   = st.conv2_inj;
    assign TIMER5_CH4_IN_O    = st.t5ch4;
    assign OPAMP_ROUTE_O      = st.opamp;
    assign OSC_PINS_AS_GPIO_O = st.osc_gpio;
    assign CAN_PIN_SET_O      = st.can_set;
    assign TIMER4_PIN_SET_O   = st.tim4;
    assign TIMER3_PIN_SET_O   = st.tim3;
    assign TIMER2_PIN_SET_O   = st.tim2;
    assign TIMER1_PIN_SET_O   = st.tim1;
    assign SERIAL3_PIN_SET_O  = st.ser3;
    assign SERIAL2_PIN_SET_O  = st.ser2;
    assign SERIAL1_PIN_SET_O  = st.ser1;
    assign TWOWIRE1_PIN_SET_O = st.twi1;
    assign SPI_ONE_PIN_SET_O  = st.spi1;

endmodule : afrb_top

`default_nettype wire

// *** afrb_chk.sv ***
// concurrent checks for the remap bank, seen from its top ports only
// assumes one clock domain and the active-low asynchronous reset
`default_nettype none

module afrb_chk
    import afrb_pkg::*;
(
    input  wire logic        MCLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        CE_I,
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_EN_I,
    input  wire logic        RD_EN_I,
    input  wire logic [31:0] RDATA_O,
    input  wire logic        CORE_EVENT_I,
    input  wire logic        TIMER8_TRIGGER_OUT_I,
    input  wire logic        TIMER8_CH4_I,
    input  wire logic [79:0] EVENT_PIN_O,
    input  wire logic [79:0] EVENT_PIN_OE_O,
    input  wire logic [15:0] LINE_OUT_O,
    input  wire logic        CONV1_REG_TRIG_O,
    input  wire logic        CONV1_INJ_TRIG_O,
    input  wire logic        CONV2_REG_TRIG_O,
    input  wire logic        CONV2_INJ_TRIG_O,
    input  wire logic [2:0]  CAN_PIN_SET_O,
    input  wire logic [2:0]  TIMER1_PIN_SET_O
);
    timeunit 1ns;
    timeprecision 1ps;

    // shadow of the remap register, so selects are known at the ports
    logic [31:0] remap;

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            remap <= 32'h0;
        end else if (CE_I && WR_EN_I && ADDR_I == REMAP_OFS) begin
            remap <= WDATA_I & REMAP_MASK;
        end
    end

    // one-hot decode of a 2-bit pin-set code; the unused code gives 0
    function automatic logic [2:0] dec3(input logic [1:0] c,
                                        input logic [1:0] gap);
        return (c == gap) ? 3'h0 : (c == 2'h0) ? 3'h1 :
               (c == 2'h3) ? 3'h4 : 3'h2;
    endfunction : dec3

    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_rd_remap;
        CE_I && RD_EN_I && ADDR_I == REMAP_OFS;
    endsequence
    // decodes are only defined once an enabled edge has passed after reset
    sequence s_live;
        $past(RST_N_I) && $past(CE_I);
    endsequence

    a_rd_idle: assert property (
        CE_I && !RD_EN_I |=> RDATA_O == 32'h0)
        else $error("read data not zero outside a read");
    a_remap_read: assert property (
        s_rd_remap |=> RDATA_O == $past(remap))
        else $error("remap read value wrong");
    a_evt_onehot: assert property (
        $onehot0(EVENT_PIN_OE_O))
        else $error("more than one event pin driven");
    a_evt_follow: assert property (
        CE_I |=> (|(EVENT_PIN_O & EVENT_PIN_OE_O)) ==
                 ($past(CORE_EVENT_I) && |EVENT_PIN_OE_O))
        else $error("event pin does not follow core event");
    a_conv2_reg: assert property (
        CE_I |=> CONV2_REG_TRIG_O == (remap[CONV2_REG_BIT] ?
            $past(TIMER8_TRIGGER_OUT_I) : $past(LINE_OUT_O[LINE_TRIG_REG])))
        else $error("converter 2 regular trigger wrong");
    a_conv2_inj: assert property (
        CE_I |=> CONV2_INJ_TRIG_O == (remap[CONV2_INJ_BIT] ?
            $past(TIMER8_CH4_I) : $past(LINE_OUT_O[LINE_TRIG_INJ])))
        else $error("converter 2 injected trigger wrong");
    a_conv1_reg: assert property (
        CE_I |=> CONV1_REG_TRIG_O == (remap[CONV1_REG_BIT] ?
            $past(TIMER8_TRIGGER_OUT_I) : $past(LINE_OUT_O[LINE_TRIG_REG])))
        else $error("converter 1 regular trigger wrong");
    a_conv1_inj: assert property (
        CE_I |=> CONV1_INJ_TRIG_O == (remap[CONV1_INJ_BIT] ?
            $past(TIMER8_CH4_I) : $past(LINE_OUT_O[LINE_TRIG_INJ])))
        else $error("converter 1 injected trigger wrong");
    a_can_decode: assert property (
        s_live |-> CAN_PIN_SET_O == dec3(remap[CAN_LSB+:2], 2'h1))
        else $error("can pin set decode wrong");
    a_timer1_decode: assert property (
        s_live |-> TIMER1_PIN_SET_O == dec3(remap[TIMER1_LSB+:2], 2'h2))
        else $error("timer1 pin set decode wrong");

endmodule : afrb_chk

bind afrb_top afrb_chk i_chk (.*);

`default_nettype wire

// *** afrb_tb.sv ***
// self-checking bench for the remap bank top
// assumes afrb_pkg, afrb_top and afrb_chk are compiled first
`default_nettype none

module tb
    import afrb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        MCLK_I, RST_N_I, CE_I, WR_EN_I, RD_EN_I, CORE_EVENT_I;
    logic        LOW_SPEED_OSC_I, TIMER8_TRIGGER_OUT_I, TIMER8_CH4_I;
    logic [7:0]  ADDR_I;
    logic [31:0] WDATA_I, RDATA_O, got;
    logic [79:0] PORT_IN_I, EVENT_PIN_O, EVENT_PIN_OE_O;
    logic [15:0] LINE_OUT_O;
    logic        CONV1_REG_TRIG_O, CONV1_INJ_TRIG_O, CONV2_REG_TRIG_O;
    logic        CONV2_INJ_TRIG_O, TIMER5_CH4_IN_O, OSC_PINS_AS_GPIO_O;
    logic        TIMER4_PIN_SET_O, SERIAL2_PIN_SET_O, SERIAL1_PIN_SET_O;
    logic        TWOWIRE1_PIN_SET_O, SPI_ONE_PIN_SET_O;
    logic [2:0]  OPAMP_ROUTE_O, CAN_PIN_SET_O, TIMER3_PIN_SET_O;
    logic [2:0]  TIMER1_PIN_SET_O, SERIAL3_PIN_SET_O;
    logic [3:0]  TIMER2_PIN_SET_O, trig;
    logic [79:0] mask;
    int          failures, comparisons;

    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } afrb_row_t;

    // reserved bits and unmapped places must come back as zero
    localparam afrb_row_t ROWS [8] = '{
        '{EVT_CTRL_OFS,   32'hffff_ffff, 32'h0000_00ff},
        '{REMAP_OFS,      32'he01f_ffff, 32'he01f_ffff},
        '{LINE_SEL_0_OFS, 32'hffff_1234, 32'h0000_1234},
        '{LINE_SEL_1_OFS, 32'h0001_4321, 32'h0000_4321},
        '{LINE_SEL_2_OFS, 32'h8000_0403, 32'h0000_0403},
        '{LINE_SEL_3_OFS, 32'h0000_ffff, 32'h0000_ffff},
        '{8'h18,          32'hffff_ffff, 32'h0000_0000},
        '{8'hfc,          32'h1234_5678, 32'h0000_0000}};
    localparam logic [2:0] E_A [4] = '{3'h1, 3'h0, 3'h2, 3'h4};
    localparam logic [2:0] E_B [4] = '{3'h1, 3'h2, 3'h0, 3'h4};

    afrb_top i_dut (.*);

    initial begin
        MCLK_I = 1'h0;
        forever #4 MCLK_I = ~MCLK_I;
    end

    // --------------------------------------------------------------
    // report and bus tasks
    // --------------------------------------------------------------
    task automatic close_out;
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk_rd(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_rd

    task automatic chk_out(input string n, input logic [79:0] e, g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_out

    // strobes drop for one cycle after each access, so no pulse merges
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ADDR_I  <= a;
        WDATA_I <= d;
        WR_EN_I <= 1'h1;
        @(posedge MCLK_I);
        WR_EN_I <= 1'h0;
        @(posedge MCLK_I);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        ADDR_I  <= a;
        RD_EN_I <= 1'h1;
        @(posedge MCLK_I);
        RD_EN_I <= 1'h0;
        @(negedge MCLK_I);
        got = RDATA_O;
        @(posedge MCLK_I);
    endtask : rd

    initial begin
        repeat (20000) @(posedge MCLK_I);
        failures++;
        close_out();
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        {RST_N_I, WR_EN_I, RD_EN_I, CORE_EVENT_I, TIMER8_CH4_I} = 5'h0;
        {CE_I, LOW_SPEED_OSC_I, TIMER8_TRIGGER_OUT_I} = 3'h6;
        {ADDR_I, WDATA_I, PORT_IN_I} = '0;
        failures = 0;
        comparisons = 0;
        repeat (4) @(posedge MCLK_I);
        RST_N_I <= 1'h1;
        @(posedge MCLK_I);
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4));
            chk_rd("reset value", 32'h0, got);
        end
        chk_out("can set", 80'h1, 80'(CAN_PIN_SET_O));
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].d);
            rd(ROWS[i].a);
            chk_rd("register", ROWS[i].e, got);
        end
        for (int c = 0; c < 4; c++) begin
            TIMER8_TRIGGER_OUT_I <= c[1];
            TIMER8_CH4_I         <= !c[1];
            wr(REMAP_OFS, (c[0] ? 32'he01f_900f : 32'h0) |
                          (32'(c) * 32'h0000_2550));
            repeat (4) @(posedge MCLK_I);
            trig = c[0] ? {c[1], !c[1], c[1], !c[1]} : 4'h0;
            chk_out("can set", 80'(E_A[c]), 80'(CAN_PIN_SET_O));
            chk_out("t3 set", 80'(E_A[c]), 80'(TIMER3_PIN_SET_O));
            chk_out("t2 set", 80'h1 << c, 80'(TIMER2_PIN_SET_O));
            chk_out("t1 set", 80'(E_B[c]), 80'(TIMER1_PIN_SET_O));
            chk_out("s3 set", 80'(E_B[c]), 80'(SERIAL3_PIN_SET_O));
            chk_out("bit sets", 80'({9{c[0]}}), 80'({OPAMP_ROUTE_O,
                OSC_PINS_AS_GPIO_O, TIMER4_PIN_SET_O, SERIAL2_PIN_SET_O,
                SERIAL1_PIN_SET_O, TWOWIRE1_PIN_SET_O,
                SPI_ONE_PIN_SET_O}));
            chk_out("triggers", 80'(trig), 80'({CONV1_REG_TRIG_O,
                CONV1_INJ_TRIG_O, CONV2_REG_TRIG_O,
                CONV2_INJ_TRIG_O}));
            chk_out("t5 ch4", 80'(c[0]), 80'(TIMER5_CH4_IN_O));
        end
        // a frozen clock enable must swallow the write
        CE_I <= 1'h0;
        wr(REMAP_OFS, 32'h0000_0001);
        CE_I <= 1'h1;
        rd(REMAP_OFS);
        chk_rd("frozen remap", 32'he01f_ffff, got);
        for (int p = 0; p < 6; p++) begin
            CORE_EVENT_I <= p[0];
            wr(EVT_CTRL_OFS, 32'h80 | 32'(p * 16 + p * 3));
            mask = (p < 5) ? 80'h1 << (p * 19) : 80'h0;
            chk_out("event oe", mask, EVENT_PIN_OE_O);
            chk_out("event pin", p[0] ? mask : 80'h0, EVENT_PIN_O);
        end
        wr(EVT_CTRL_OFS, 32'h0000_0023);
        chk_out("event off", 80'h0, EVENT_PIN_OE_O);
        PORT_IN_I <= 80'h0f0f_3c3c_a5a5_1234_c3e1;
        for (int c = 0; c < 6; c++) begin
            for (int r = 0; r < 4; r++) begin
                wr(8'(8 + r * 4), 32'(c) * 32'h0000_1111);
            end
            repeat (2) @(posedge MCLK_I);
            mask = (c < 5) ? 80'(PORT_IN_I[c * 16 +: 16]) : 80'h0;
            chk_out("line out", mask, 80'(LINE_OUT_O));
        end
        // reset in mid-run returns every register to zero
        RST_N_I <= 1'h0;
        repeat (2) @(posedge MCLK_I);
        RST_N_I <= 1'h1;
        @(posedge MCLK_I);
        rd(REMAP_OFS);
        chk_rd("remap after reset", 32'h0, got);
        chk_out("can after reset", 80'h1, 80'(CAN_PIN_SET_O));
        close_out();
    end

endmodule : tb

`default_nettype wire
